//--- src/tsi_params.svh
/*
 * Constants of the temperature sensor command front end: bus addresses,
 * command codes, checksum parameters and timing counts at the 250 MHz clock.
 * Assumes inclusion by bare name before the modules that use it.
 */
`ifndef TSI_PARAMS_SVH
`define TSI_PARAMS_SVH

`define TSI_MCLK_MHZ      250
`define TSI_ADDR_LOW      7'h44
`define TSI_ADDR_HIGH     7'h45
`define TSI_CMD_MSB_STR   8'h2C
`define TSI_CMD_MSB_NOSTR 8'h24
`define TSI_LSB_STR_HIGH  8'h06
`define TSI_LSB_STR_MED   8'h0D
`define TSI_LSB_STR_LOW   8'h10
`define TSI_LSB_NS_HIGH   8'h00
`define TSI_LSB_NS_MED    8'h0B
`define TSI_LSB_NS_LOW    8'h16
`define TSI_CRC_POLY      8'h31
`define TSI_CRC_INIT      8'hFF
// Times as printed, then cycle counts derived from the clock rate
`define TSI_PU_TIME_US    1000
`define TSI_RST_PULSE_NS  350
`define TSI_MEAS_LOW_US   4000
`define TSI_MEAS_MED_US   6000
`define TSI_MEAS_HIGH_US  15000
`define TSI_PU_CYC        (`TSI_PU_TIME_US * `TSI_MCLK_MHZ)
`define TSI_RST_CYC       ((`TSI_RST_PULSE_NS * `TSI_MCLK_MHZ + 999) / 1000)
`define TSI_MEAS_LOW_CYC  (`TSI_MEAS_LOW_US * `TSI_MCLK_MHZ)
`define TSI_MEAS_MED_CYC  (`TSI_MEAS_MED_US * `TSI_MCLK_MHZ)
`define TSI_MEAS_HIGH_CYC (`TSI_MEAS_HIGH_US * `TSI_MCLK_MHZ)

`endif

//--- src/tsi_pkg.sv
/*
 * Types of the temperature sensor command front end.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tsi_pkg;

  // Bus engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RECV = 6'h02,
    ST_ACK  = 6'h04,
    ST_SEND = 6'h08,
    ST_MACK = 6'h10,
    ST_HOLD = 6'h20
  } tsi_state_t;

  typedef enum logic [1:0] {
    REP_LOW  = 2'h0,
    REP_MED  = 2'h1,
    REP_HIGH = 2'h2
  } tsi_rep_t;

  // Pins that cross into the clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic addr;
    logic rst_n;
  } tsi_pins_t;

  // Decoded measurement command
  typedef struct packed {
    logic     valid;
    logic     stretch;
    tsi_rep_t rep;
  } tsi_cmd_t;

endpackage

//--- src/tsi_sync.sv
/*
 * Two-flop synchroniser for the pin group.
 * Assumes the pins are asynchronous to i_mclk; first stage feeds only the second.
 */
`timescale 1ns/10ps
`default_nettype none
module tsi_sync
  import tsi_pkg::*;
(
  input  wire logic      i_mclk,
  input  wire logic      i_reset_n,
  input  wire tsi_pins_t i_pins,
  output var tsi_pins_t  o_pins
);
  tsi_pins_t stage1;

  // Idle levels are high: released bus, deasserted reset
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage1 <= '1;
      o_pins <= '1;
    end else begin
      stage1 <= i_pins;
      o_pins <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- src/tsi_crc8.sv
/*
 * Checksum over a 16-bit data word, most significant byte first.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none
`include "tsi_params.svh"
module tsi_crc8
  import tsi_pkg::*;
(
  input  wire logic [15:0] i_data,
  output logic      [7:0]  o_crc
);
  // Bitwise shift register form, unrolled by the loop
  always_comb begin
    o_crc = `TSI_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (o_crc[7] ^ i_data[i]) begin
        o_crc = {o_crc[6:0], 1'b0} ^ `TSI_CRC_POLY;
      end else begin
        o_crc = {o_crc[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

//--- src/tsi_top.sv
/*
 * Bus target and single-shot measurement control of a temperature sensor.
 * Assumes open-drain pads outside (output enable low-drives the wire) and a
 * sensor core that presents its 16-bit result on i_temp_data in this clock.
 */
// Functional notes
// - Address 0x44 pin low, 0x45 pin high
// - Header: seven address bits, then read bit
// - Commands decoded from all sixteen bits
// - Every data word followed by checksum
// - Written data without valid checksum discarded; commands here are taken with no checksum
// - Ready for commands within power-up time
// - Hardware reset active low, idles deasserted
// - Measurement ends within 4/6/15 ms
// - Idle entered automatically, no user control
// - START opens transaction, STOP optional
// - Acknowledge low from eighth falling edge
// - Measurement starts on command acknowledge
// - Six single-shot codes, 0x2C and 0x24
// - Read sends two data bytes, checksum
// - No stretching: NACK read without result
// - Stretching: ACK, hold clock until done
// - Works at any clock up to 1 MHz
// - Pins only pulled low or released
`timescale 1ns/10ps
`default_nettype none
`include "tsi_params.svh"
module tsi_top
  import tsi_pkg::*;
#(
  parameter int unsigned PU_CYC        = `TSI_PU_CYC,
  parameter int unsigned MEAS_LOW_CYC  = `TSI_MEAS_LOW_CYC,
  parameter int unsigned MEAS_MED_CYC  = `TSI_MEAS_MED_CYC,
  parameter int unsigned MEAS_HIGH_CYC = `TSI_MEAS_HIGH_CYC
)(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_addr_sel,
  input  wire logic        i_hw_reset_low_pin,
  input  wire logic [15:0] i_temp_data,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  output logic             o_scl_out,
  output logic             o_scl_oe,
  output logic             o_ready,
  output logic             o_meas_start,
  output logic             o_meas_busy,
  output logic [1:0]       o_meas_rep
);
  tsi_pins_t pins;
  tsi_pins_t pin;
  logic      scl_prev, sda_prev;
  logic      scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] crc_now;

  assign pins = '{scl: i_scl, sda: i_sda, addr: i_addr_sel, rst_n: i_hw_reset_low_pin};

  tsi_sync u_sync (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_pins    (pins),
    .o_pins    (pin)
  );

  tsi_crc8 u_crc (
    .i_data (i_temp_data),
    .o_crc  (crc_now)
  );

  // Edge and bus condition detection on the synchronised lines
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= pin.scl;
      sda_prev <= pin.sda;
    end
  end
  // Oversampling at 250 MHz covers any bus clock up to 1 MHz
  assign scl_rise   = pin.scl & ~scl_prev;
  assign scl_fall   = ~pin.scl & scl_prev;
  assign start_cond = pin.scl & scl_prev & sda_prev & ~pin.sda;
  assign stop_cond  = pin.scl & scl_prev & ~sda_prev & pin.sda;

  // Measurement length per repeatability, worst case figures
  function automatic logic [21:0] meas_len(input tsi_rep_t r);
    unique case (r)
      REP_LOW: meas_len = 22'(MEAS_LOW_CYC);
      REP_MED: meas_len = 22'(MEAS_MED_CYC);
      default: meas_len = 22'(MEAS_HIGH_CYC);
    endcase
  endfunction

  // Full 16-bit command match, command MSB and LSB both compared
  function automatic tsi_cmd_t decode_cmd(input logic [15:0] c);
    decode_cmd = '{valid: 1'b1, stretch: 1'b1, rep: REP_HIGH};
    unique case (c)
      {`TSI_CMD_MSB_STR, `TSI_LSB_STR_HIGH}:  decode_cmd.rep = REP_HIGH;
      {`TSI_CMD_MSB_STR, `TSI_LSB_STR_MED}:   decode_cmd.rep = REP_MED;
      {`TSI_CMD_MSB_STR, `TSI_LSB_STR_LOW}:   decode_cmd.rep = REP_LOW;
      {`TSI_CMD_MSB_NOSTR, `TSI_LSB_NS_HIGH}: decode_cmd = '{1'b1, 1'b0, REP_HIGH};
      {`TSI_CMD_MSB_NOSTR, `TSI_LSB_NS_MED}:  decode_cmd = '{1'b1, 1'b0, REP_MED};
      {`TSI_CMD_MSB_NOSTR, `TSI_LSB_NS_LOW}:  decode_cmd = '{1'b1, 1'b0, REP_LOW};
      default:                               decode_cmd = '{1'b0, 1'b0, REP_LOW};
    endcase
  endfunction

  // Power-up and pin reset state
  logic [6:0]  rst_cnt, next_rst_cnt;
  logic [17:0] pu_cnt, next_pu_cnt;
  logic        clr, next_clr, next_ready;

  // Pin reset counted before acting: short glitches are ignored
  always_comb begin
    next_rst_cnt = rst_cnt;
    next_clr     = 1'b0;
    next_pu_cnt  = pu_cnt;
    next_ready   = o_ready;
    if (!pin.rst_n) begin
      if (rst_cnt != 7'(`TSI_RST_CYC)) next_rst_cnt = rst_cnt + 7'h01;
      next_clr = (rst_cnt == 7'(`TSI_RST_CYC));
    end else begin
      next_rst_cnt = 7'h00;
    end
    if (clr) begin
      next_pu_cnt = 18'h00000;
      next_ready  = 1'b0;
    end else if (!o_ready) begin
      next_pu_cnt = pu_cnt + 18'h00001;
      next_ready  = (pu_cnt == 18'(PU_CYC - 1));
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_cnt <= 7'h00;
      clr     <= 1'b0;
      pu_cnt  <= 18'h00000;
      o_ready <= 1'b0;
    end else begin
      rst_cnt <= next_rst_cnt;
      clr     <= next_clr;
      pu_cnt  <= next_pu_cnt;
      o_ready <= next_ready;
    end
  end

  // Bus engine state
  tsi_state_t st, next_st;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg, cmd_hi, next_cmd_hi;
  logic [1:0] byte_idx, next_byte_idx;
  logic       is_hdr, next_is_hdr, is_read, next_is_read, do_ack, next_do_ack;
  logic       addr_lat, next_addr_lat, mack_ok, next_mack_ok;
  logic       next_sda_oe, next_scl_oe, start_req, next_start_req;
  tsi_cmd_t   req_cmd, next_req_cmd, dec;
  // Measurement state
  logic [21:0] mcnt, next_mcnt;
  logic        stretch_mode, next_stretch_mode, res_valid, next_res_valid;
  logic        next_busy, next_meas_start;
  logic [15:0] res_data, next_res_data;
  logic [7:0]  res_crc, next_res_crc;
  logic [1:0]  next_rep;

  // Readout order: high data byte, low data byte, checksum
  function automatic logic [7:0] tx_byte(input logic [1:0] idx);
    unique case (idx)
      2'h0:    tx_byte = res_data[15:8];
      2'h1:    tx_byte = res_data[7:0];
      default: tx_byte = res_crc;
    endcase
  endfunction

  assign dec = decode_cmd({cmd_hi, shreg});

  always_comb begin
    next_st        = st;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_cmd_hi    = cmd_hi;
    next_byte_idx  = byte_idx;
    next_is_hdr    = is_hdr;
    next_is_read   = is_read;
    next_do_ack    = do_ack;
    next_addr_lat  = addr_lat;
    next_mack_ok   = mack_ok;
    next_sda_oe    = o_sda_oe;
    next_scl_oe    = o_scl_oe;
    next_start_req = 1'b0;
    next_req_cmd   = req_cmd;
    if (clr) begin
      next_st     = ST_IDLE;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
    end else if (start_cond) begin
      // Address pin taken at START, held by the master
      next_st       = ST_RECV;
      next_bit_cnt  = 4'h0;
      next_is_hdr   = 1'b1;
      next_byte_idx = 2'h0;
      next_addr_lat = pin.addr;
      next_sda_oe   = 1'b0;
      next_scl_oe   = 1'b0;
    end else if (stop_cond) begin
      next_st     = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          next_sda_oe = 1'b0; // Automatic idle after any transfer
        end
        ST_RECV: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], pin.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_st = ST_ACK;
            if (is_hdr) begin
              next_is_hdr  = 1'b0;
              next_is_read = shreg[0];
              next_do_ack  = (shreg[7:1] == (addr_lat ? `TSI_ADDR_HIGH : `TSI_ADDR_LOW))
                & (shreg[0] ? (res_valid | (o_meas_busy & stretch_mode))
                            : (o_ready & ~o_meas_busy));
            end else if (byte_idx == 2'h0) begin
              // Command arrives MSB first
              next_cmd_hi   = shreg;
              next_byte_idx = 2'h1;
              next_do_ack   = (shreg == `TSI_CMD_MSB_STR) | (shreg == `TSI_CMD_MSB_NOSTR);
            end else if (byte_idx == 2'h1) begin
              next_byte_idx  = 2'h2;
              next_do_ack    = dec.valid;
              next_start_req = dec.valid;
              next_req_cmd   = dec;
            end else begin
              next_do_ack = 1'b0; // Extra written bytes dropped unchecked
            end
            next_sda_oe = next_do_ack;
          end
        end
        ST_ACK: begin
          // Byte index kept: a write needs it to tell the command LSB from the MSB
          if (scl_fall) begin
            next_bit_cnt  = 4'h0;
            if (!do_ack) begin
              next_st     = ST_IDLE;
              next_sda_oe = 1'b0;
            end else if (!is_read) begin
              next_st     = ST_RECV;
              next_sda_oe = 1'b0;
            end else if (res_valid) begin
              next_st     = ST_SEND;
              next_shreg  = tx_byte(2'h0);
              next_sda_oe = ~next_shreg[7];
            end else begin
              next_st     = ST_HOLD;
              next_sda_oe = 1'b0;
              next_scl_oe = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          // Clock held low until the result lands
          if (res_valid) begin
            next_st     = ST_SEND;
            next_shreg  = tx_byte(2'h0);
            next_sda_oe = ~next_shreg[7];
            next_scl_oe = 1'b0;
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              next_st     = ST_MACK;
              next_sda_oe = 1'b0;
            end else begin
              next_shreg   = {shreg[6:0], 1'b0};
              next_sda_oe  = ~shreg[6]; // Zero pulls low, one releases
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            next_mack_ok = ~pin.sda;
          end else if (scl_fall) begin
            // Master NACK ends the readout at any byte
            if (mack_ok && byte_idx != 2'h2) begin
              next_st       = ST_SEND;
              next_byte_idx = byte_idx + 2'h1;
              next_shreg    = tx_byte(byte_idx + 2'h1);
              next_sda_oe   = ~next_shreg[7];
              next_bit_cnt  = 4'h0;
            end else begin
              next_st = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st        <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      cmd_hi    <= 8'h00;
      byte_idx  <= 2'h0;
      is_hdr    <= 1'b0;
      is_read   <= 1'b0;
      do_ack    <= 1'b0;
      addr_lat  <= 1'b0;
      mack_ok   <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_scl_oe  <= 1'b0;
      o_sda_out <= 1'b0;
      o_scl_out <= 1'b0;
      start_req <= 1'b0;
      req_cmd   <= '{1'b0, 1'b0, REP_LOW};
    end else begin
      st        <= next_st;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      cmd_hi    <= next_cmd_hi;
      byte_idx  <= next_byte_idx;
      is_hdr    <= next_is_hdr;
      is_read   <= next_is_read;
      do_ack    <= next_do_ack;
      addr_lat  <= next_addr_lat;
      mack_ok   <= next_mack_ok;
      o_sda_oe  <= next_sda_oe;
      o_scl_oe  <= next_scl_oe;
      o_sda_out <= 1'b0; // Open drain: only low is ever driven
      o_scl_out <= 1'b0;
      start_req <= next_start_req;
      req_cmd   <= next_req_cmd;
    end
  end

  // Measurement timer and result capture with checksum
  always_comb begin
    next_busy         = o_meas_busy;
    next_mcnt         = mcnt;
    next_rep          = o_meas_rep;
    next_stretch_mode = stretch_mode;
    next_res_valid    = res_valid;
    next_res_data     = res_data;
    next_res_crc      = res_crc;
    next_meas_start   = 1'b0;
    if (clr) begin
      next_busy      = 1'b0;
      next_res_valid = 1'b0;
    end else if (start_req) begin
      next_busy         = 1'b1;
      next_mcnt         = 22'h000000;
      next_rep          = req_cmd.rep;
      next_stretch_mode = req_cmd.stretch;
      next_res_valid    = 1'b0;
      next_meas_start   = 1'b1;
    end else if (o_meas_busy) begin
      next_mcnt = mcnt + 22'h000001;
      if (mcnt == meas_len(tsi_rep_t'(o_meas_rep)) - 22'h000001) begin
        next_busy      = 1'b0;
        next_res_valid = 1'b1;
        next_res_data  = i_temp_data;
        next_res_crc   = crc_now;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_meas_busy  <= 1'b0;
      mcnt         <= 22'h000000;
      o_meas_rep   <= REP_LOW;
      stretch_mode <= 1'b0;
      res_valid    <= 1'b0;
      res_data     <= 16'h0000;
      res_crc      <= 8'h00;
      o_meas_start <= 1'b0;
    end else begin
      o_meas_busy  <= next_busy;
      mcnt         <= next_mcnt;
      o_meas_rep   <= next_rep;
      stretch_mode <= next_stretch_mode;
      res_valid    <= next_res_valid;
      res_data     <= next_res_data;
      res_crc      <= next_res_crc;
      o_meas_start <= next_meas_start;
    end
  end

  property p_addr_nack;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (st == ST_RECV && scl_fall && bit_cnt == 4'h8 && is_hdr && !start_cond && !stop_cond
     && !clr && shreg[7:1] != {6'h22, addr_lat}) |=> !do_ack ##1 (st != ST_SEND);
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("wrong address acknowledged");
  property p_rw_bit;
    @(posedge i_mclk) disable iff (!i_reset_n)
    $fell(is_hdr) && st == ST_ACK |-> is_read == $past(shreg[0]);
  endproperty
  a_rw_bit: assert property (p_rw_bit) else $error("read bit not taken from header");
  property p_ack_drive;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (st == ST_ACK && do_ack) |-> o_sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven low");
  property p_start_meas;
    @(posedge i_mclk) disable iff (!i_reset_n)
    start_req && !clr |-> o_sda_oe ##1 (o_meas_start && o_meas_busy);
  endproperty
  a_start_meas: assert property (p_start_meas) else $error("measurement not started on ack");
  property p_meas_bound;
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_meas_busy |-> mcnt < meas_len(tsi_rep_t'(o_meas_rep));
  endproperty
  a_meas_bound: assert property (p_meas_bound) else $error("measurement overran its limit");
  property p_busy_refuse;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (st == ST_RECV && scl_fall && bit_cnt == 4'h8 && is_hdr && !shreg[0] && !start_cond
     && !stop_cond && !clr && (!o_ready || o_meas_busy)) |=> !do_ack;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("command taken while busy");
  property p_no_result_nack;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (st == ST_RECV && scl_fall && bit_cnt == 4'h8 && is_hdr && shreg[0] && !start_cond
     && !stop_cond && !clr && !res_valid && !(o_meas_busy && stretch_mode)) |=> !do_ack;
  endproperty
  a_no_result_nack: assert property (p_no_result_nack) else $error("read acked without data");
  property p_stretch_release;
    @(posedge i_mclk) disable iff (!i_reset_n)
    $fell(o_scl_oe) && st == ST_SEND |-> $past(res_valid) && o_sda_oe == ~res_data[15];
  endproperty
  a_stretch_release: assert property (p_stretch_release) else $error("clock released early");
  property p_powerup;
    @(posedge i_mclk) disable iff (!i_reset_n)
    !o_ready |-> pu_cnt < 18'(PU_CYC);
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up time exceeded");
  property p_open_drain;
    @(posedge i_mclk) disable iff (!i_reset_n)
    !o_sda_out && !o_scl_out && byte_idx != 2'h3;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
endmodule
`default_nettype wire

//--- verif/tsi_master.sv
/* Bus master model: open-drain SCL and SDA, 64 ns bit time.
   Assumes the bench resolves both wires with pull-ups. */
`timescale 1ns/10ps
`default_nettype none
module tsi_master
(
  input  wire logic i_mclk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  int stalls = 0;
  // Lines only pulled low or released
  initial begin
    o_scl_low = 0;
    o_sda_low = 0;
  end
  // Quarter bit, moving at the falling mclk edge
  task automatic q();
    repeat (4) @(negedge i_mclk);
  endtask
  // Release SCL; high phase counted from when the wire really rises
  task automatic hi();
    int n;
    n = 0;
    o_scl_low = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (!i_scl && n < 5000);
    if (n >= 5000) stalls++;
    repeat (7) @(negedge i_mclk);
  endtask
  // START, also repeated
  task automatic start();
    q();
    o_sda_low = 0;
    q();
    hi();
    o_sda_low = 1;
    q();
    o_scl_low = 1;
  endtask
  task automatic stop();
    q();
    o_sda_low = 1;
    q();
    hi();
    o_sda_low = 0;
    q();
  endtask
  // Data set mid low phase, so no false START or STOP
  task automatic bit_x(input logic v, output logic r);
    q();
    o_sda_low = !v;
    q();
    hi();
    r = i_sda;
    o_scl_low = 1;
  endtask
  task automatic wr(input logic [7:0] w, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(w[i], a);
    bit_x(1'b1, a);
    ack = !a;
  endtask
  // NACK on last byte ends the readout
  task automatic rd(input logic last, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, r[i]);
    bit_x(last, a);
  endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
/* Bench of the sensor bus front end with short power-up and measure counts.
   Assumes tsi_master drives the bus and the sensor core is the temp value. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  // Measure counts long enough that the busy-time refusals are really hit
  localparam int PU = 400, ML = 600, MM = 800, MH = 1000;
  localparam logic [15:0] CMDS [6] = '{16'h2C06, 16'h2C0D, 16'h2C10,
                                       16'h2400, 16'h240B, 16'h2416};
  logic        clk = 0, rst_n = 0, asel = 0, hwr_n = 1;
  logic [15:0] temp = 16'h0000;
  logic        sda_oe, scl_oe, ready, mstart, busy, ms_l, md_l, sda_o, scl_o;
  logic [1:0]  rep;
  // Pull-ups win unless a side drives its output level
  wire logic   scl = !ms_l & (scl_oe ? scl_o : 1'b1);
  wire logic   sda = !md_l & (sda_oe ? sda_o : 1'b1);
  int          miscompares = 0, n_compared = 0, starts = 0, bcnt = 0;
  time         t0;
  always #2 clk = ~clk;
  // Pulse and busy-length counters
  always @(posedge clk) begin
    if (mstart) starts++;
    if (busy) bcnt++;
  end
  tsi_top #(.PU_CYC(PU), .MEAS_LOW_CYC(ML), .MEAS_MED_CYC(MM), .MEAS_HIGH_CYC(MH)) uut (
    .i_mclk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda), .i_addr_sel(asel),
    .i_hw_reset_low_pin(hwr_n), .i_temp_data(temp), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
    .o_scl_out(scl_o), .o_scl_oe(scl_oe), .o_ready(ready), .o_meas_start(mstart),
    .o_meas_busy(busy), .o_meas_rep(rep));
  tsi_master m (.i_mclk(clk), .i_scl(scl), .i_sda(sda), .o_scl_low(ms_l), .o_sda_low(md_l));
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %0t %s: %h not %h", $time, what, got, exp);
      miscompares++;
    end
  endtask
  // Bounded wait until the flag reaches the level; a hang ends the run
  task automatic wait_lvl(input bit on_busy, input logic v);
    int n;
    n = 0;
    while ((on_busy ? busy : ready) !== v && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      miscompares++;
      stop_test();
    end
  endtask
  // Bench's own checksum, MSB first
  function automatic logic [7:0] crc(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic hdr(input logic [6:0] ad, input logic rw, output logic ack);
    m.start();
    m.wr({ad, rw}, ack);
  endtask
  task automatic t_power();
    logic a;
    hdr(7'h44, 1'b0, a);
    chk(16'(a), 16'h0000, "early header");
    m.stop();
    wait_lvl(1'b0, 1'b1);
    chk(16'(($time - t0) / 4 >= PU && ($time - t0) / 4 <= PU + 4), 16'h0001, "power-up time");
    $display("t_power done");
  endtask
  task automatic t_bad();
    logic a;
    int s0;
    s0 = starts;
    hdr(7'h44, 1'b0, a);
    m.wr(8'h2C, a);
    chk(16'(a), 16'h0001, "msb");
    m.wr(8'h07, a);
    chk(16'(a), 16'h0000, "bad lsb");
    hdr(7'h44, 1'b0, a);
    m.wr(8'h25, a);
    chk(16'(a), 16'h0000, "bad msb");
    m.stop();
    chk(16'(starts - s0), 16'h0000, "no start");
    $display("t_bad done");
  endtask
  task automatic t_cmd(input int i);
    logic a;
    logic [7:0] b0, b1, b2;
    logic [6:0] ad;
    int s0, len;
    @(negedge clk);
    asel = i[0]; // Steady for each transaction
    ad = i[0] ? 7'h45 : 7'h44;
    temp = 16'hB4E1 ^ 16'(i << 5);
    len = (i % 3 == 0) ? MH : (i % 3 == 1) ? MM : ML;
    repeat (8) @(negedge clk);
    hdr(ad ^ 7'h01, 1'b0, a);
    chk(16'(a), 16'h0000, "foreign address");
    s0 = starts;
    bcnt = 0;
    hdr(ad, 1'b0, a);
    chk(16'(a), 16'h0001, "write header");
    m.wr(CMDS[i][15:8], a);
    chk(16'(a), 16'h0001, "cmd msb");
    m.wr(CMDS[i][7:0], a);
    chk(16'(a), 16'h0001, "cmd lsb");
    repeat (8) @(negedge clk);
    chk(16'(starts - s0), 16'h0001, "start pulse");
    chk(16'(rep), 16'(2 - i % 3), "repeatability");
    hdr(ad, 1'b1, a);
    if (i < 3) begin
      chk(16'(a), 16'h0001, "stretch read");
    end else begin
      chk(16'(a), 16'h0000, "early read");
      hdr(ad, 1'b0, a);
      chk(16'(a), 16'h0000, "write while busy");
      m.stop();
      wait_lvl(1'b1, 1'b0);
      hdr(ad, 1'b1, a);
      m.rd(1'b0, b0);
      m.rd(1'b1, b1);
      chk({b0, b1}, temp, "data, no checksum");
      hdr(ad, 1'b1, a);
      chk(16'(a), 16'h0001, "reread");
    end
    m.rd(1'b0, b0);
    m.rd(1'b0, b1);
    m.rd(1'b1, b2);
    m.stop();
    chk({b0, b1}, temp, "data");
    chk(16'(b2), 16'(crc(temp)), "checksum");
    chk(16'(bcnt >= len - 1 && bcnt <= len + 2), 16'h0001, "measure length");
    $display("t_cmd %0d done", i);
  endtask
  task automatic t_hwrst();
    logic a;
    @(negedge clk);
    hwr_n = 0; // Low for 400 ns
    repeat (100) @(negedge clk);
    hwr_n = 1;
    repeat (4) @(negedge clk);
    chk(16'(ready), 16'h0000, "pin reset");
    wait_lvl(1'b0, 1'b1);
    hdr(7'h45, 1'b1, a);
    m.stop();
    chk(16'(a), 16'h0000, "result cleared");
    $display("t_hwrst done");
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    t0 = $time;
    t_power();
    t_bad();
    for (int i = 0; i < 6; i++) t_cmd(i);
    t_hwrst();
    chk(16'(m.stalls), 16'h0000, "stretch bound");
    chk(16'({sda_o, scl_o}), 16'h0000, "drive level");
    stop_test();
  end
  // Watchdog on the whole run
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
